// ==== nvs_dev_model.sv ====
/*
 Behavioural model of the nonvolatile SRAM seen by the host controller.
 Assumes pins are sampled on the system clock of the bench.
*/
module nvs_dev_model
    import nvs_pkg::*;
(
    // Clock and test control
    input wire logic i_clk_sys,
    input wire logic [7:0] i_save_cyc,
    input wire logic i_power_fail,
    output logic [7:0] o_save_count,
    // Memory pins
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic i_cs_n,
    input wire logic i_oe_n,
    input wire logic i_we_n,
    input wire logic i_ub_n,
    input wire logic i_lb_n,
    input wire logic i_word_mode,
    input wire logic [DATA_W-1:0] i_dq,
    output logic [DATA_W-1:0] o_dq,
    output logic [1:0] o_dq_oe,
    input wire logic i_pin,
    output logic o_pin,
    output logic o_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HI_CYC = 3;
    logic [15:0] mem [0:262143];
    logic [17:0] key;
    logic [17:0] kw_q;
    logic [16:0] a_q;
    logic [15:0] d_q;
    logic [1:0] l_q;
    logic rd;
    logic wr;
    logic rd_q = 0;
    logic wr_q = 0;
    logic latch = 0;
    logic pl_en = 1;
    int seq = 0;
    int busy = 0;
    initial o_save_count = 8'h00;
    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    assign key = i_word_mode ? {2'b00, i_addr[15:0]} : {1'b1, i_addr};
    assign rd = !i_cs_n && !i_oe_n && i_we_n && i_pin;
    assign wr = !i_cs_n && !i_we_n && i_pin;
    assign o_dq = mem[key];
    assign o_dq_oe = !rd ? 2'b00 :
        i_word_mode ? {!i_ub_n, !i_lb_n} : 2'b01;
    assign o_pin_oe = busy > 0;
    assign o_pin = busy <= HI_CYC;
    // ------------------------------------------------------------
    // Writes, sequence and saves
    // ------------------------------------------------------------
    always @(posedge i_clk_sys) begin
        rd_q <= rd;
        wr_q <= wr;
        if (rd) a_q <= i_addr;
        if (wr) begin
            kw_q <= key;
            d_q <= i_dq;
            l_q <= i_word_mode ? {!i_ub_n, !i_lb_n} : 2'b01;
        end
        if (busy > 0) begin
            busy <= busy - 1;
            if (busy == HI_CYC + 1) begin
                latch <= 0;
                o_save_count <= o_save_count + 8'h01;
            end
        end else if (wr_q && !wr) begin
            if (l_q[0]) mem[kw_q][7:0] <= d_q[7:0];
            if (l_q[1]) mem[kw_q][15:8] <= d_q[15:8];
            latch <= 1;
            seq <= 0;
        end else if (rd_q && !rd) begin
            if (seq == 5) begin
                if (a_q[15:0] == SEQ_ADDR[5]) busy <= i_save_cyc + HI_CYC + 1;
                if (a_q[15:0] == SEQ_PL_OFF) pl_en <= 0;
                if (a_q[15:0] == SEQ_PL_ON) pl_en <= 1;
                seq <= 0;
            end else if (a_q[15:0] == SEQ_ADDR[seq]) begin
                seq <= seq + 1;
            end else begin
                seq <= (a_q[15:0] == SEQ_ADDR[0]) ? 1 : 0;
            end
        end else if (latch && (!i_pin || (i_power_fail && pl_en))) begin
            busy <= i_save_cyc + HI_CYC + 1;
        end
    end
endmodule

// ==== nvs_host.sv ====
/*
 Host controller for the nonvolatile SRAM port: read, write, hardware
 save request on the store-busy pin, software save sequence.
 Assumes the device pins are synchronous to i_clk_sys.
*/
module nvs_host
    import nvs_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Command port
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire logic [1:0] i_cmd_op,
    input wire logic [ADDR_W-1:0] i_cmd_addr,
    input wire logic [DATA_W-1:0] i_cmd_wdata,
    input wire logic [1:0] i_cmd_lanes,
    input wire logic i_word_mode,
    input wire logic i_no_capacitor,
    output logic o_rsp_valid,
    output logic [DATA_W-1:0] o_rsp_rdata,
    output logic o_write_pending,
    output logic o_busy_timeout,
    // Device pins
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic o_chip_sel_n,
    output logic o_out_drive_n,
    output logic o_write_n,
    output logic o_upper_byte_lane_n,
    output logic o_lower_byte_lane_n,
    input wire logic [DATA_W-1:0] i_mem_dq,
    output logic [DATA_W-1:0] o_mem_dq,
    output logic o_mem_dq_oe,
    input wire logic i_store_busy_pin,
    output logic o_store_busy_pin,
    output logic o_store_busy_pin_oe
);
    nvs_state_type state_q;
    nvs_op_type op_q;
    logic [2:0] seq_idx_q;
    logic seq_mode_q;
    logic pl_off_done_q;
    logic [18:0] busy_cnt_q;
    logic [ADDR_W-1:0] seq_addr;
    nvs_tim_if tif ();
    default clocking cb_sys @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);

    nvs_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .t(tif.tim)
    );
    // ------------------------------------------------------------
    // Sequence address
    // ------------------------------------------------------------
    always_comb begin
        seq_addr = '0;
        seq_addr[15:0] = (!pl_off_done_q && seq_idx_q == 3'h5) ?
            SEQ_PL_OFF : SEQ_ADDR[seq_idx_q];
    end
    // ------------------------------------------------------------
    // Timer control
    // ------------------------------------------------------------
    always_comb begin
        tif.start = 1'b0;
        tif.count = TIM_W;
        if (state_q == NVS_IDLE) begin
            tif.start = seq_mode_q || (o_cmd_ready && i_cmd_valid);
            tif.count = 4'(SETUP_CYC);
        end else if (state_q == NVS_SETUP) begin
            tif.start = tif.done;
            tif.count = op_q == NVS_OP_WRITE ? 4'(WRITE_PULSE_CYC) :
                4'(ADDR_ACCESS_CYC);
        end else if (state_q == NVS_READ || state_q == NVS_WRITE) begin
            tif.start = tif.done;
            tif.count = 4'h1;
        end
    end
    // Busy low means device saving or restoring
    assign o_cmd_ready = state_q == NVS_IDLE && !seq_mode_q &&
        i_store_busy_pin && (pl_off_done_q || !i_no_capacitor);
    // ------------------------------------------------------------
    // Main state machine
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            state_q <= NVS_IDLE;
            op_q <= NVS_OP_READ;
            seq_mode_q <= 1'b0;
            seq_idx_q <= 3'h0;
        end else begin
            case (state_q)
                NVS_IDLE: begin
                    if (seq_mode_q) begin
                        state_q <= NVS_SETUP;
                        op_q <= NVS_OP_SWSEQ;
                    end else if (!pl_off_done_q && i_no_capacitor) begin
                        seq_mode_q <= 1'b1;
                        seq_idx_q <= 3'h0;
                    end else if (o_cmd_ready && i_cmd_valid) begin
                        op_q <= nvs_op_type'(i_cmd_op);
                        if (nvs_op_type'(i_cmd_op) == NVS_OP_HWSAVE) begin
                            state_q <= NVS_HWREQ;
                        end else if (nvs_op_type'(i_cmd_op) ==
                            NVS_OP_SWSEQ) begin
                            seq_mode_q <= 1'b1;
                            seq_idx_q <= 3'h0;
                        end else begin
                            state_q <= NVS_SETUP;
                        end
                    end
                end
                NVS_SETUP: begin
                    if (tif.done) begin
                        state_q <= op_q == NVS_OP_WRITE ? NVS_WRITE :
                            NVS_READ;
                    end
                end
                NVS_READ: if (tif.done) state_q <= NVS_HOLD;
                NVS_WRITE: if (tif.done) state_q <= NVS_HOLD;
                NVS_HOLD: begin
                    if (tif.done) begin
                        if (op_q == NVS_OP_SWSEQ) begin
                            if (seq_idx_q == 3'(SEQ_LEN - 1)) begin
                                seq_mode_q <= 1'b0;
                                state_q <= pl_off_done_q ? NVS_BUSY : NVS_IDLE;
                            end else begin
                                seq_idx_q <= seq_idx_q + 3'h1;
                                state_q <= NVS_IDLE;
                            end
                        end else begin
                            state_q <= NVS_IDLE;
                        end
                    end
                end
                NVS_HWREQ: if (!i_store_busy_pin) state_q <= NVS_BUSY;
                NVS_BUSY: if (i_store_busy_pin || o_busy_timeout)
                    state_q <= NVS_IDLE;
                default: state_q <= NVS_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Power-loss save disable, one sequence after reset
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            pl_off_done_q <= 1'b0;
        end else if (!i_no_capacitor || (state_q == NVS_HOLD &&
            op_q == NVS_OP_SWSEQ && seq_idx_q == 3'h5 && tif.done)) begin
            pl_off_done_q <= 1'b1;
        end
    end
    // ------------------------------------------------------------
    // Busy watchdog and write-pending mirror
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || (state_q != NVS_BUSY && state_q != NVS_HWREQ)) begin
            busy_cnt_q <= 19'h0;
            o_busy_timeout <= 1'b0;
        end else if (busy_cnt_q == 19'(BUSY_LIMIT_CYC)) begin
            o_busy_timeout <= 1'b1;
        end else begin
            busy_cnt_q <= busy_cnt_q + 19'h1;
        end
    end
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_write_pending <= 1'b0;
        end else if (state_q == NVS_WRITE && tif.done) begin
            o_write_pending <= 1'b1;
        end else if (state_q == NVS_BUSY && i_store_busy_pin) begin
            o_write_pending <= 1'b0;
        end
    end
    // ------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_mem_addr <= '0;
            o_mem_dq <= '0;
        end else if (state_q == NVS_IDLE && seq_mode_q) begin
            o_mem_addr <= seq_addr;
        end else if (state_q == NVS_IDLE && o_cmd_ready && i_cmd_valid) begin
            o_mem_addr <= i_word_mode ?
                {1'b0, i_cmd_addr[WORD_ADDR_W-1:0]} : i_cmd_addr;
            o_mem_dq <= i_cmd_wdata;
        end
    end
    assign o_chip_sel_n = !(state_q == NVS_READ || state_q == NVS_WRITE);
    assign o_out_drive_n = state_q != NVS_READ;
    assign o_write_n = !(state_q == NVS_WRITE);
    assign o_mem_dq_oe = state_q == NVS_WRITE || (state_q == NVS_SETUP &&
        op_q == NVS_OP_WRITE);
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_upper_byte_lane_n <= 1'b1;
            o_lower_byte_lane_n <= 1'b1;
        end else if (state_q == NVS_IDLE && o_cmd_ready && i_cmd_valid) begin
            o_upper_byte_lane_n <= !(i_cmd_lanes[1] || !i_word_mode);
            o_lower_byte_lane_n <= !(i_cmd_lanes[0] || !i_word_mode);
        end else if (state_q == NVS_IDLE && seq_mode_q) begin
            o_upper_byte_lane_n <= 1'b0;
            o_lower_byte_lane_n <= 1'b0;
        end
    end
    // Only pull low, never high
    assign o_store_busy_pin = 1'b0;
    assign o_store_busy_pin_oe = state_q == NVS_HWREQ;
    // ------------------------------------------------------------
    // Read response
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp_rdata <= '0;
        end else begin
            o_rsp_valid <= state_q == NVS_READ && tif.done &&
                op_q == NVS_OP_READ;
            if (state_q == NVS_READ && tif.done) begin
                o_rsp_rdata <= i_mem_dq;
            end
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_write_oe_high;
        !o_write_n |-> o_out_drive_n;
    endproperty
    a_write_oe_high: assert property (p_write_oe_high)
        else $error("output drive low during write");
    property p_addr_stable;
        !o_write_n && $past(!o_write_n) |-> $stable(o_mem_addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("address moved during write");
    property p_busy_low_only;
        o_store_busy_pin_oe |-> !o_store_busy_pin;
    endproperty
    a_busy_low_only: assert property (p_busy_low_only)
        else $error("busy pin driven high");
    property p_no_access_busy;
        state_q == NVS_BUSY |-> o_chip_sel_n;
    endproperty
    a_no_access_busy: assert property (p_no_access_busy)
        else $error("access while device busy");
    property p_read_strobes;
        !o_out_drive_n |-> !o_chip_sel_n && o_write_n && !o_mem_dq_oe;
    endproperty
    a_read_strobes: assert property (p_read_strobes)
        else $error("bad read strobes");
    property p_pending_set;
        state_q == NVS_WRITE && tif.done |=> o_write_pending;
    endproperty
    a_pending_set: assert property (p_pending_set)
        else $error("write pending not set");
    property p_seq_write_high;
        seq_mode_q |-> o_write_n;
    endproperty
    a_seq_write_high: assert property (p_seq_write_high)
        else $error("write during save sequence");
    property p_write_data_drive;
        $fell(o_write_n) |-> o_mem_dq_oe && $past(o_mem_dq_oe);
    endproperty
    a_write_data_drive: assert property (p_write_data_drive)
        else $error("write data not set up");
endmodule

// ==== nvs_if.sv ====
/*
 Interface joining the host controller to its timer.
 Assumes one clock shared by both ends.
*/
interface nvs_tim_if;
    logic start;
    logic [3:0] count;
    logic done;
    modport ctrl (output start, output count, input done);
    modport tim (input start, input count, output done);
endinterface

// ==== nvs_pkg.sv ====
/*
 Package for the nonvolatile SRAM host controller: widths, software
 save sequence, timing counts and state enumeration.
 Assumes a 25 MHz system clock.
*/
package nvs_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned WORD_ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned BYTE_DEPTH = 131072;
    localparam int unsigned WORD_DEPTH = 65536;
    // ------------------------------------------------------------
    // Software save sequence
    // ------------------------------------------------------------
    localparam int unsigned SEQ_LEN = 6;
    localparam logic [15:0] SEQ_ADDR [SEQ_LEN] = '{
        16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f, 16'h8fc0};
    localparam logic [15:0] SEQ_PL_OFF = 16'h8b45;
    localparam logic [15:0] SEQ_PL_ON = 16'h4b46;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned ADDR_ACCESS_NS = 25;
    localparam int unsigned ADDR_ACCESS_CYC =
        (ADDR_ACCESS_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (ADDR_ACCESS_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WRITE_PULSE_NS = 20;
    localparam int unsigned WRITE_PULSE_CYC =
        (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SETUP_NS = 40;
    localparam int unsigned SETUP_CYC =
        (SETUP_NS * CLK_MHZ + 999) / 1000 < 1 ? 1 :
        (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned BUSY_LIMIT_CYC = 500000;
    localparam logic [3:0] TIM_W = 4'h4;
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        NVS_IDLE, NVS_SETUP, NVS_READ, NVS_WRITE, NVS_HOLD,
        NVS_HWREQ, NVS_BUSY
    } nvs_state_type;
    typedef enum logic [1:0] {
        NVS_OP_READ, NVS_OP_WRITE, NVS_OP_HWSAVE, NVS_OP_SWSEQ
    } nvs_op_type;
endpackage

// ==== nvs_timer.sv ====
/*
 Cycle down counter for strobe phases of the host controller.
 Assumes start pulses only while idle or at the end of a phase.
*/
module nvs_timer
    import nvs_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Control
    nvs_tim_if.tim t
);
    logic [3:0] cnt_q;
    logic run_q;
    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            cnt_q <= 4'h0;
            run_q <= 1'b0;
        end else if (t.start) begin
            cnt_q <= t.count;
            run_q <= 1'b1;
        end else if (run_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else begin
            run_q <= 1'b0;
        end
    end
    assign t.done = run_q && (cnt_q == 4'h0);
endmodule

// ==== tb_top.sv ====
/*
 Self-checking bench for the host controller against the device model.
 Assumes the package constants and the hand-over timing of the host.
*/
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import nvs_pkg::*;
    logic i_clk_sys, i_reset_n, i_cmd_valid, o_cmd_ready, i_word_mode;
    logic [1:0] i_cmd_op, i_cmd_lanes, dq_oe;
    logic [16:0] i_cmd_addr, o_mem_addr, wa;
    logic [15:0] i_cmd_wdata, o_rsp_rdata, o_mem_dq, dev_dq, bus;
    logic [15:0] last = 16'h0000;
    logic o_rsp_valid, o_write_pending, o_chip_sel_n, o_out_drive_n;
    logic o_write_n, ub_n, lb_n, o_mem_dq_oe, o_store_busy_pin;
    logic o_store_busy_pin_oe, pin, pin_out, pin_oe, power_fail, got;
    logic no_cap, busy_to;
    logic wn_q = 1;
    logic [7:0] save_cyc, save_count, n0;
    int fail_count = 0;
    int num_checks = 0;
    int cyc = 0;
    // ------------------------------------------------------------
    // Wires, instances
    // ------------------------------------------------------------
    assign bus[7:0] = o_mem_dq_oe ? o_mem_dq[7:0] :
        dq_oe[0] ? dev_dq[7:0] : ~last[7:0];
    assign bus[15:8] = o_mem_dq_oe ? o_mem_dq[15:8] :
        dq_oe[1] ? dev_dq[15:8] : ~last[15:8];
    assign pin = o_store_busy_pin_oe ? o_store_busy_pin :
        pin_oe ? pin_out : 1'b1;
    always @(posedge i_clk_sys) last <= bus;
    nvs_host i_dut (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_cmd_valid(i_cmd_valid), .o_cmd_ready(o_cmd_ready),
        .i_cmd_op(i_cmd_op), .i_cmd_addr(i_cmd_addr),
        .i_cmd_wdata(i_cmd_wdata), .i_cmd_lanes(i_cmd_lanes),
        .i_word_mode(i_word_mode), .i_no_capacitor(no_cap),
        .o_rsp_valid(o_rsp_valid), .o_rsp_rdata(o_rsp_rdata),
        .o_write_pending(o_write_pending), .o_busy_timeout(busy_to),
        .o_mem_addr(o_mem_addr), .o_chip_sel_n(o_chip_sel_n),
        .o_out_drive_n(o_out_drive_n), .o_write_n(o_write_n),
        .o_upper_byte_lane_n(ub_n), .o_lower_byte_lane_n(lb_n),
        .i_mem_dq(bus), .o_mem_dq(o_mem_dq), .o_mem_dq_oe(o_mem_dq_oe),
        .i_store_busy_pin(pin), .o_store_busy_pin(o_store_busy_pin),
        .o_store_busy_pin_oe(o_store_busy_pin_oe));
    nvs_dev_model i_dev (.i_clk_sys(i_clk_sys), .i_save_cyc(save_cyc),
        .i_power_fail(power_fail), .o_save_count(save_count),
        .i_addr(o_mem_addr), .i_cs_n(o_chip_sel_n), .i_oe_n(o_out_drive_n),
        .i_we_n(o_write_n), .i_ub_n(ub_n), .i_lb_n(lb_n),
        .i_word_mode(i_word_mode), .i_dq(bus), .o_dq(dev_dq),
        .o_dq_oe(dq_oe), .i_pin(pin), .o_pin(pin_out), .o_pin_oe(pin_oe));
    // ------------------------------------------------------------
    // Check, report, pin monitor
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(negedge i_clk_sys) begin
        wa <= o_mem_addr;
        wn_q <= o_write_n;
        if (!o_write_n) check(o_out_drive_n, 1);
        if (!o_write_n && !wn_q) check(o_mem_addr, wa);
        if (o_store_busy_pin_oe) check(o_store_busy_pin, 0);
        if (pin_oe && !pin_out) check(o_chip_sel_n, 1);
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            final_report;
        end
    end
    // ------------------------------------------------------------
    // Command and scenarios
    // ------------------------------------------------------------
    task automatic cmd(input logic [1:0] op, input logic [16:0] a,
                       input logic [15:0] d, input logic [1:0] ln);
        int n;
        i_cmd_op = op;
        i_cmd_addr = a;
        i_cmd_wdata = d;
        i_cmd_lanes = ln;
        i_cmd_valid = 1;
        for (n = 0; n < 1000 && o_cmd_ready !== 1'b1; n++) @(posedge i_clk_sys) #1;
        @(posedge i_clk_sys);
        #1;
        i_cmd_valid = 0;
        got = 0;
        for (n = 0; n < 1000; n++) begin
            if (o_rsp_valid === 1'b1) got = 1;
            if (o_cmd_ready === 1'b1) break;
            @(posedge i_clk_sys);
            #1;
        end
        check(n < 1000, 1);
    endtask
    task automatic t_word;
        cmd(1, 17'h0ffff, 16'ha5c3, 2'b11);
        check(o_write_pending, 1);
        cmd(1, 17'h00000, 16'h3c3c, 2'b11);
        cmd(0, 17'h0ffff, 16'h0000, 2'b11);
        check(got, 1);
        check(o_rsp_rdata, 16'ha5c3);
        cmd(1, 17'h0ffff, 16'h5a77, 2'b10);
        cmd(0, 17'h0ffff, 16'h0000, 2'b11);
        check(o_rsp_rdata, 16'h5ac3);
        cmd(0, 17'h0ffff, 16'h0000, 2'b01);
        check(o_rsp_rdata[7:0], 8'hc3);
        cmd(0, 17'h00000, 16'h0000, 2'b11);
        check(o_rsp_rdata, 16'h3c3c);
    endtask
    task automatic t_byte;
        i_word_mode = 0;
        cmd(1, 17'h1fffe, 16'h00e1, 2'b00);
        cmd(1, 17'h0fffe, 16'h007b, 2'b00);
        cmd(0, 17'h1fffe, 16'h0000, 2'b00);
        check(o_rsp_rdata[7:0], 8'he1);
        cmd(0, 17'h0fffe, 16'h0000, 2'b00);
        check(o_rsp_rdata[7:0], 8'h7b);
        i_word_mode = 1;
    endtask
    task automatic t_hw;
        save_cyc = 8'd5;
        n0 = save_count;
        cmd(2, 17'h00000, 16'h0000, 2'b00);
        check(save_count, n0 + 8'd1);
        cmd(2, 17'h00000, 16'h0000, 2'b00);
        check(save_count, n0 + 8'd1);
        check(o_write_pending, 0);
        check(busy_to, 0);
    endtask
    task automatic t_sw;
        save_cyc = 8'd200;
        n0 = save_count;
        cmd(3, 17'h00000, 16'h0000, 2'b00);
        check(save_count, n0 + 8'd1);
    endtask
    task automatic t_power;
        int n;
        cmd(1, 17'h00010, 16'h1111, 2'b11);
        n0 = save_count;
        power_fail = 1;
        @(posedge i_clk_sys);
        #1;
        power_fail = 0;
        check(o_cmd_ready, 0);
        for (n = 0; n < 400 && pin_oe !== 1'b0; n++) @(posedge i_clk_sys) #1;
        check(save_count, n0 + 8'd1);
    endtask
    task automatic t_nocap;
        i_reset_n = 0;
        no_cap = 1;
        repeat (4) @(posedge i_clk_sys);
        #1;
        i_reset_n = 1;
        check(o_cmd_ready, 0);
        cmd(1, 17'h00020, 16'h2222, 2'b11);
        n0 = save_count;
        power_fail = 1;
        @(posedge i_clk_sys);
        #1;
        power_fail = 0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        check(o_cmd_ready, 1);
        check(save_count, n0);
    endtask
    initial begin
        i_clk_sys = 0;
        forever #20 i_clk_sys = ~i_clk_sys;
    end
    initial begin
        i_reset_n = 0;
        i_cmd_valid = 0;
        i_cmd_op = 2'b00;
        i_cmd_addr = 17'h00000;
        i_cmd_wdata = 16'h0000;
        i_cmd_lanes = 2'b00;
        i_word_mode = 1;
        save_cyc = 8'd5;
        power_fail = 0;
        no_cap = 0;
        repeat (4) @(posedge i_clk_sys);
        #1;
        i_reset_n = 1;
        t_word;
        t_byte;
        t_hw;
        t_sw;
        t_power;
        t_nocap;
        final_report;
    end
endmodule
